// file: rtl/cca_regs.vh
// register map, field positions, reset values and timing for the channel assessment block
// assumes a 32-bit word-aligned ahb-lite register window
`ifndef CCA_REGS_VH
`define CCA_REGS_VH

// byte offsets
`define CCA_OFS_CONFIG 8'h00
`define CCA_OFS_STATUS 8'h04
`define CCA_OFS_THRES 8'h08
`define CCA_OFS_RXSYNC 8'h0C
`define CCA_OFS_IRQ_STS 8'h10
`define CCA_OFS_IRQ_MASK 8'h14

// channel_and_assess_config_reg fields
`define CCA_CFG_MODE_LSB 0
`define CCA_CFG_MODE_MSB 1
`define CCA_CFG_REQ_BIT 7

// transceiver_status_reg fields
`define CCA_STS_DONE_BIT 0
`define CCA_STS_IDLE_BIT 1
`define CCA_STS_RUN_BIT 2
`define CCA_STS_AUTOED_BIT 3

// assess_threshold_reg field
`define CCA_THR_LSB 0
`define CCA_THR_MSB 3

// rx_sync_config_reg field
`define CCA_RXS_PDT_DIS_BIT 7

// interrupt status and mask field
`define CCA_IRQ_DONE_BIT 0

// reset values
`define CCA_RST_MODE 2'h1
`define CCA_RST_THRES 4'h7
`define CCA_RST_PDT_DIS 1'h0
`define CCA_RST_MASK 1'h0

// timing
`define CCA_CLK_NS 25
`define CCA_T_MEAS_NS 128000
`define CCA_T_RESULT_NS 140000
`define CCA_T_AUTO_ED_NS 128000
`define CCA_MEAS_CYC ((`CCA_T_MEAS_NS + `CCA_CLK_NS - 1) / `CCA_CLK_NS)
`define CCA_RESULT_CYC ((`CCA_T_RESULT_NS + `CCA_CLK_NS - 1) / `CCA_CLK_NS)
`define CCA_AUTO_ED_CYC ((`CCA_T_AUTO_ED_NS + `CCA_CLK_NS - 1) / `CCA_CLK_NS)

`endif

// file: rtl/cca_top.v
// clear channel assessment control with ahb-lite register slave
// assumes baseband status inputs come from logic on ref_clk
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cca_regs.vh"

// Functional notes
// - mode 1: busy when energy over threshold
// - mode 2: busy only on carrier detect
// - mode 0 or-combines, mode 3 and-combines
// - request bit starts assessment in rx
// - idle rx: eight symbols, result 140us
// - completion raises shared done interrupt
// - threshold is base plus twice field
// - request write clears done and idle
// - done set; idle set if clear
// - carrier sense over base sensitivity level
// - request outside rx still completes, no measurement
// - busy rx: wait for auto energy end
// - busy rx mode 2: result immediately
// - one auto energy measurement per frame
// - preamble disable keeps idle rx, 8 symbols
// - base sensitivity level is minus 90 dBm
module cca_top #(
  parameter CNT_W = 16,
  parameter MEAS_CYC = `CCA_MEAS_CYC,
  parameter RESULT_CYC = `CCA_RESULT_CYC,
  parameter AUTO_ED_CYC = `CCA_AUTO_ED_CYC
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // ahb-lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // baseband status
  input wire basic_mode,
  input wire rx_idle_state,
  input wire rx_busy_state,
  input wire shr_detect,
  input wire carrier_detect,
  input wire [7:0] energy_level,
  // receiver control and interrupt
  output reg preamble_detect_disable_bit,
  output reg assess_energy_done_irq
);

  localparam ST_IDLE = 4'h1;
  localparam ST_MEAS = 4'h2;
  localparam ST_WAIT_ED = 4'h4;
  localparam ST_FINISH = 4'h8;

  // bus address phase capture
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg rd_pend_q;
  reg [7:0] rd_addr_q;
  wire addr_ok;
  wire wr_take;
  wire rd_take;
  wire wr_data_now;

  // configuration state
  reg [1:0] mode_cfg_q;
  reg [3:0] thres_q;
  reg mask_q;
  reg irq_sts_q;

  // assessment state
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [1:0] mode_run_q;
  reg [CNT_W-1:0] cnt_q;
  reg busy_acc_q;
  reg done_q;
  reg idle_q;
  reg finish_busy_q;

  // automatic energy measurement
  reg ed_run_q;
  reg ed_used_q;
  reg [CNT_W-1:0] ed_cnt_q;
  reg ed_above_q;
  reg ed_result_q;
  wire ed_end;

  // channel evaluation
  wire energy_above;
  wire carrier_busy;
  wire req_write;
  wire in_rx;
  reg busy_now;
  reg finish_pulse;
  reg finish_val;
  reg [31:0] rd_mux;

  assign addr_ok = hsel && hready && htrans[1];
  assign wr_take = addr_ok && hwrite;
  assign rd_take = addr_ok && !hwrite;
  assign wr_data_now = wr_pend_q;

  // energy level counts 1 dB steps above base sensitivity level
  assign energy_above = energy_level > {3'h0, thres_q, 1'b0};
  assign carrier_busy = carrier_detect;

  assign req_write = wr_data_now && (wr_addr_q == `CCA_OFS_CONFIG) &&
    hwdata[`CCA_CFG_REQ_BIT];
  assign in_rx = basic_mode && (rx_idle_state || rx_busy_state);
  assign ed_end = ed_run_q && (ed_cnt_q == AUTO_ED_CYC - 1);

  // busy decision for the frozen mode
  always @* begin
    case (mode_run_q)
      2'h0: busy_now = carrier_busy || energy_above;
      2'h1: busy_now = energy_above;
      2'h2: busy_now = carrier_busy;
      2'h3: busy_now = carrier_busy && energy_above;
      default: busy_now = 1'b0;
    endcase
  end

  // next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_IDLE;
      end
      ST_MEAS: begin
        if (cnt_q == RESULT_CYC - 1) begin
          state_d = ST_FINISH;
        end
      end
      ST_WAIT_ED: begin
        if (ed_end || !ed_run_q) begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (req_write) begin
      if (!in_rx) begin
        state_d = ST_FINISH;
      end else if (rx_busy_state && !preamble_detect_disable_bit) begin
        if (hwdata[`CCA_CFG_MODE_MSB:`CCA_CFG_MODE_LSB] == 2'h2) begin
          state_d = ST_FINISH;
        end else if (ed_run_q) begin
          state_d = ST_WAIT_ED;
        end else begin
          state_d = ST_FINISH;
        end
      end else begin
        state_d = ST_MEAS;
      end
    end
  end

  // finish strobe and result
  always @* begin
    finish_pulse = (state_q == ST_FINISH);
    finish_val = !finish_busy_q;
  end

  // assessment sequencer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      mode_run_q <= `CCA_RST_MODE;
      cnt_q <= {CNT_W{1'b0}};
      busy_acc_q <= 1'b0;
      finish_busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (req_write) begin
        mode_run_q <= hwdata[`CCA_CFG_MODE_MSB:`CCA_CFG_MODE_LSB];
        cnt_q <= {CNT_W{1'b0}};
        busy_acc_q <= 1'b0;
        finish_busy_q <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            cnt_q <= {CNT_W{1'b0}};
          end
          ST_MEAS: begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            if (cnt_q < MEAS_CYC) begin
              busy_acc_q <= busy_acc_q || busy_now;
            end
            finish_busy_q <= busy_acc_q;
          end
          ST_WAIT_ED: begin
            finish_busy_q <= 1'b1;
          end
          default: begin
            cnt_q <= cnt_q;
          end
        endcase
      end
      if (state_q == ST_MEAS && state_d == ST_FINISH && !req_write) begin
        finish_busy_q <= busy_acc_q || ((cnt_q < MEAS_CYC) && busy_now);
      end
      if (state_q == ST_WAIT_ED && !req_write) begin
        case (mode_run_q)
          2'h0: finish_busy_q <= carrier_busy || ed_above_q || energy_above;
          2'h3: finish_busy_q <= carrier_busy && (ed_above_q || energy_above);
          default: finish_busy_q <= ed_above_q || energy_above;
        endcase
      end
      if (req_write && state_d == ST_FINISH && in_rx) begin
        case (hwdata[`CCA_CFG_MODE_MSB:`CCA_CFG_MODE_LSB])
          2'h0: finish_busy_q <= carrier_busy || ed_result_q;
          2'h1: finish_busy_q <= ed_result_q;
          2'h2: finish_busy_q <= carrier_busy;
          default: finish_busy_q <= carrier_busy && ed_result_q;
        endcase
      end
    end
  end

  // automatic energy measurement after sync header
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ed_run_q <= 1'b0;
      ed_used_q <= 1'b0;
      ed_cnt_q <= {CNT_W{1'b0}};
      ed_above_q <= 1'b0;
      ed_result_q <= 1'b0;
    end else begin
      if (!rx_busy_state && !ed_run_q) begin
        ed_used_q <= 1'b0;
      end
      if (shr_detect && !ed_used_q && !ed_run_q && !preamble_detect_disable_bit) begin
        ed_run_q <= 1'b1;
        ed_used_q <= 1'b1;
        ed_cnt_q <= {CNT_W{1'b0}};
        ed_above_q <= energy_above;
      end else if (ed_run_q) begin
        ed_cnt_q <= ed_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        ed_above_q <= ed_above_q || energy_above;
        if (ed_end) begin
          ed_run_q <= 1'b0;
          ed_result_q <= ed_above_q || energy_above;
        end
      end
    end
  end

  // completion and channel flags
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      if (finish_pulse) begin
        done_q <= 1'b1;
        idle_q <= finish_val && in_rx;
      end else if (req_write) begin
        done_q <= 1'b0;
        idle_q <= 1'b0;
      end
    end
  end

  // bus write path
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      mode_cfg_q <= `CCA_RST_MODE;
      thres_q <= `CCA_RST_THRES;
      preamble_detect_disable_bit <= `CCA_RST_PDT_DIS;
      mask_q <= `CCA_RST_MASK;
      irq_sts_q <= 1'b0;
      assess_energy_done_irq <= 1'b0;
    end else begin
      if (hready) begin
        wr_pend_q <= wr_take;
        wr_addr_q <= haddr;
      end
      if (wr_data_now) begin
        case (wr_addr_q)
          `CCA_OFS_CONFIG: begin
            mode_cfg_q <= hwdata[`CCA_CFG_MODE_MSB:`CCA_CFG_MODE_LSB];
          end
          `CCA_OFS_THRES: begin
            thres_q <= hwdata[`CCA_THR_MSB:`CCA_THR_LSB];
          end
          `CCA_OFS_RXSYNC: begin
            preamble_detect_disable_bit <= hwdata[`CCA_RXS_PDT_DIS_BIT];
          end
          `CCA_OFS_IRQ_MASK: begin
            mask_q <= hwdata[`CCA_IRQ_DONE_BIT];
          end
          default: begin
            mask_q <= mask_q;
          end
        endcase
      end
      // set wins over write-one-to-clear
      if (finish_pulse) begin
        irq_sts_q <= 1'b1;
      end else if (wr_data_now && (wr_addr_q == `CCA_OFS_IRQ_STS) &&
        hwdata[`CCA_IRQ_DONE_BIT]) begin
        irq_sts_q <= 1'b0;
      end
      assess_energy_done_irq <= (irq_sts_q || finish_pulse) && mask_q;
    end
  end

  // read mux
  always @* begin
    rd_mux = 32'h00000000;
    case (rd_addr_q)
      `CCA_OFS_CONFIG: begin
        rd_mux[`CCA_CFG_MODE_MSB:`CCA_CFG_MODE_LSB] = mode_cfg_q;
      end
      `CCA_OFS_STATUS: begin
        rd_mux[`CCA_STS_DONE_BIT] = done_q;
        rd_mux[`CCA_STS_IDLE_BIT] = idle_q;
        rd_mux[`CCA_STS_RUN_BIT] = !state_q[0];
        rd_mux[`CCA_STS_AUTOED_BIT] = ed_run_q;
      end
      `CCA_OFS_THRES: begin
        rd_mux[`CCA_THR_MSB:`CCA_THR_LSB] = thres_q;
      end
      `CCA_OFS_RXSYNC: begin
        rd_mux[`CCA_RXS_PDT_DIS_BIT] = preamble_detect_disable_bit;
      end
      `CCA_OFS_IRQ_STS: begin
        rd_mux[`CCA_IRQ_DONE_BIT] = irq_sts_q;
      end
      `CCA_OFS_IRQ_MASK: begin
        rd_mux[`CCA_IRQ_DONE_BIT] = mask_q;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // bus read path and response
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      // one wait state so a read sees a write just before it
      hreadyout <= !rd_take;
      hresp <= 1'b0;
      rd_pend_q <= rd_take;
      if (rd_take) begin
        rd_addr_q <= haddr;
      end
      if (rd_pend_q) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule // cca_top
`default_nettype wire

// file: testbench/cca_top_sva.sv
// port assertions for cca_top
// assumes one clock domain, bound into every cca_top
`timescale 1ns/10ps
`default_nettype none
module cca_chk #(
  parameter RESULT_CYC = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // baseband and outputs
  input wire logic basic_mode,
  input wire logic rx_idle_state,
  input wire logic rx_busy_state,
  input wire logic preamble_detect_disable_bit,
  input wire logic assess_energy_done_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  localparam int RMAX = RESULT_CYC + 4;
  logic aph_q, wr_q, mask_q;
  logic [7:0] adr_q;
  wire dw = aph_q & wr_q & hready;
  wire dr = aph_q & !wr_q & hready;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aph_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      mask_q <= 1'b0;
    end else begin
      if (hready) begin
        aph_q <= hsel & htrans[1];
        wr_q <= hwrite;
        adr_q <= haddr;
      end
      if (dw && adr_q == 8'h14) mask_q <= hwdata[0];
    end
  end
  wire req = dw && adr_q == 8'h00 && hwdata[7];
  wire in_rx = basic_mode & (rx_idle_state | rx_busy_state);
  wire irq = assess_energy_done_irq;
  // idle rx request: quiet, then done
  sequence s_req_idle;
    req && basic_mode && rx_idle_state && !rx_busy_state && mask_q && !irq;
  endsequence
  sequence s_quiet;
    !irq [*8];
  endsequence
  property p_bus; !hresp && (hreadyout || $past(hreadyout)); endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
  property p_cfg_rd; dr && adr_q == 8'h00 |-> !hrdata[7]; endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("request bit reads one");
  property p_rd_pdt; dr && adr_q == 8'h0C |-> hrdata[7] == preamble_detect_disable_bit; endproperty
  a_rd_pdt: assert property (p_rd_pdt) else $error("rx sync read wrong");
  property p_pdt_wr;
    dw && adr_q == 8'h0C |=> preamble_detect_disable_bit == $past(hwdata[7]);
  endproperty
  a_pdt_wr: assert property (p_pdt_wr) else $error("disable bit not written");
  property p_pdt_hold;
    !(dw && adr_q == 8'h0C) |=> $stable(preamble_detect_disable_bit);
  endproperty
  a_pdt_hold: assert property (p_pdt_hold) else $error("disable bit moved");
  property p_mask; !mask_q [*3] |-> !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt high");
  property p_out_rx; req && !in_rx && mask_q |-> ##[1:4] irq; endproperty
  a_out_rx: assert property (p_out_rx) else $error("no done outside rx");
  property p_busy_m2;
    req && basic_mode && rx_busy_state && !preamble_detect_disable_bit
      && hwdata[1:0] == 2'h2 && mask_q |-> ##[1:4] irq;
  endproperty
  a_busy_m2: assert property (p_busy_m2) else $error("mode 2 busy rx late");
  property p_idle_time; s_req_idle |=> s_quiet ##[1:RMAX] irq; endproperty
  a_idle_time: assert property (p_idle_time) else $error("idle rx timing wrong");
endmodule // cca_chk
bind cca_top cca_chk #(.RESULT_CYC(RESULT_CYC)) u_chk (.ref_clk, .rst_n, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .basic_mode,
  .rx_idle_state, .rx_busy_state, .preamble_detect_disable_bit, .assess_energy_done_irq);
`default_nettype wire

// file: testbench/cca_top_tb.sv
// self-checking bench for cca_top
// assumes cca_top_sva.sv is compiled before it
`timescale 1ns/10ps
`default_nettype none
module cca_top_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, shr_detect = 1'b0;
  logic basic_mode = 1'b1, rx_idle_state = 1'b1, rx_busy_state = 1'b0;
  logic carrier_detect = 1'b0;
  logic [7:0] haddr = 8'h00, energy_level = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, s;
  wire [31:0] hrdata;
  wire hready, pdd, irq;
  int miscompares = 0;
  int tests_run = 0;
  // mode, threshold, energy, carrier, idle result
  logic [15:0] rows [10] = '{16'h5C3B, 16'h5C3C, 16'h8141, 16'h8002, 16'h0C1C,
    16'h0C19, 16'h0C02, 16'hCC1D, 16'hCC1E, 16'hCC1B};
  logic [39:0] rv [7] = '{40'h0000000001, 40'h0400000000, 40'h0800000007,
    40'h0C00000000, 40'h1000000000, 40'h1400000000, 40'h2000000000};
  cca_top #(.MEAS_CYC(8), .RESULT_CYC(12), .AUTO_ED_CYC(8)) dut (.ref_clk(ref_clk),
    .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(), .basic_mode(basic_mode), .rx_idle_state(rx_idle_state),
    .rx_busy_state(rx_busy_state), .shr_detect(shr_detect), .carrier_detect(carrier_detect),
    .energy_level(energy_level), .preamble_detect_disable_bit(pdd),
    .assess_energy_done_irq(irq));
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic edge_rdy;
    int n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    s = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wait_done;
    int n = 0;
    do begin
      rd(8'h04);
      n++;
    end while (s[0] !== 1'b1 && n < 40);
    if (s[0] !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic clr_irq;
    chk_pin("irq", 1'b1, irq);
    wr(8'h10, 32'h1);
    rd(8'h10);
    chk("irq_sts", 32'h0, s);
    chk_pin("irq", 1'b0, irq);
  endtask
  task automatic shr_pulse;
    shr_detect <= 1'b1;
    @(posedge ref_clk);
    shr_detect <= 1'b0;
    rd(8'h04);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    wr(8'h20, 32'hFFFFFFFF);
    foreach (rv[i]) begin
      rd(rv[i][39:32]);
      chk("reset", rv[i][31:0], s);
    end
    wr(8'h14, 32'h1);
    foreach (rows[i]) begin
      carrier_detect <= rows[i][1];
      energy_level <= rows[i][9:2];
      wr(8'h08, {28'h0, rows[i][13:10]});
      wr(8'h00, {24'h0, 6'h20, rows[i][15:14]});
      wait_done();
      chk("status", {30'h0, rows[i][0], 1'b1}, s);
      clr_irq();
    end
    wr(8'h00, 32'h81);
    rd(8'h04);
    chk("status", 32'h4, s);
    wait_done();
    clr_irq();
    for (int k = 0; k < 2; k++) begin
      basic_mode <= k[0];
      rx_idle_state <= !k[0];
      wr(8'h00, 32'h81);
      wait_done();
      chk("status", 32'h1, s);
      clr_irq();
    end
    basic_mode <= 1'b1;
    rx_busy_state <= 1'b1;
    carrier_detect <= 1'b0;
    energy_level <= 8'h50;
    wr(8'h00, 32'h82);
    wait_done();
    chk("status", 32'h3, s);
    clr_irq();
    shr_pulse();
    chk("status", 32'hB, s);
    wr(8'h00, 32'h81);
    rd(8'h04);
    chk("status", 32'hC, s);
    wait_done();
    chk("status", 32'h1, s);
    clr_irq();
    shr_pulse();
    chk("status", 32'h1, s);
    energy_level <= 8'h00;
    wr(8'h00, 32'h83);
    wait_done();
    chk("status", 32'h3, s);
    clr_irq();
    wr(8'h0C, 32'h80);
    rd(8'h0C);
    chk("rxsync", 32'h80, s);
    chk_pin("pdd", 1'b1, pdd);
    carrier_detect <= 1'b1;
    wr(8'h00, 32'h82);
    rd(8'h04);
    rd(8'h04);
    chk("status", 32'h4, s);
    wait_done();
    chk("status", 32'h1, s);
    clr_irq();
    wr(8'h0C, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h81);
    wait_done();
    chk_pin("irq", 1'b0, irq);
    rd(8'h10);
    chk("irq_sts", 32'h1, s);
    print_verdict();
  end
endmodule // cca_top_tb
`default_nettype wire
